//--- tg_top.sv
// traffic test logic: rx frame and crc counters, packet generator,
// serial prbs generator and checker, all behind an axi4-lite slave
// assumes rx paths flag frame end and crc result, one byte per clock
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tg_consts.svh"
module tg_top
	import tg_pkg::*;
#(
	parameter logic [5:0] LOCK_BITS = `TG_LOCK_BITS
) (
	input  wire logic           SYS_CLK_I,
	input  wire logic           NRST_I,
	input  wire logic [7:0]     AWADDR_I,
	input  wire logic           AWVALID_I,
	output      logic           AWREADY_O,
	input  wire logic [31:0]    WDATA_I,
	input  wire logic [3:0]     WSTRB_I,
	input  wire logic           WVALID_I,
	output      logic           WREADY_O,
	output      logic [1:0]     BRESP_O,
	output      logic           BVALID_O,
	input  wire logic           BREADY_I,
	input  wire logic [7:0]     ARADDR_I,
	input  wire logic           ARVALID_I,
	output      logic           ARREADY_O,
	output      logic [31:0]    RDATA_O,
	output      logic [1:0]     RRESP_O,
	output      logic           RVALID_O,
	input  wire logic           RREADY_I,
	input  wire logic [2:0]     RX_EOF_I,
	input  wire logic [2:0]     RX_CRC_BAD_I,
	input  wire tg_beat_t [2:0] NORM_TX_I,
	output      tg_beat_t [2:0] TX_O,
	output      logic           SER_TX_O,
	input  wire logic           SER_RX_I
);

	localparam logic [2:0] PATH_CODE [3] = '{`TG_PATH_COPPER,
		`TG_PATH_SERIAL, `TG_PATH_PAR};

	tg_main_state_t s_q;
	tg_main_state_t s_d;
	tg_beat_t [2:0] tx_nx;
	tg_beat_t       gen_beat;
	logic [2:0]     eof_hit;
	logic [2:0]     bad_hit;
	logic           gen_busy;
	logic           pkt_done;
	logic           gen_bit;
	logic           chk_err;
	logic           chk_lock;
	logic           wr_fire;
	logic           rd_fire;
	logic [16:0]    wr_look;
	logic [16:0]    rd_look;
	logic [15:0]    wd;

	// readback: hit flag on top, self-clearing bits always read zero
	function automatic logic [16:0] rd_val(input logic [7:0] a,
		input tg_main_state_t s);
		logic [16:0] r;
		r = 17'h00000;
		if (a == `TG_OFF_RXCTL) begin
			r = {1'b1, 13'h0000, s.rx_path};
		end else if (a == `TG_OFF_CNTS) begin
			r = {1'b1, s.fcnt, s.ecnt};
		end else if (a == `TG_OFF_PGCTL) begin
			r = {1'b1, s.pg_burst, s.pg_path, 2'h0, s.pg_fixed,
				s.pg_long, s.pg_bad};
		end else if (a == `TG_OFF_PRBSCTL) begin
			r = {1'b1, 8'h00, s.chk_pol, s.gen_pol, s.lockreq, 1'b0,
				s.pat, s.chk_en, s.gen_en};
		end else if (a == `TG_OFF_ERRLO) begin
			r = {1'b1, s.perr[15:0]};
		end else if (a == `TG_OFF_ERRHI) begin
			r = {1'b1, s.phi};
		end
		return r;
	endfunction

	generate
		for (genvar i = 0; i < 3; i++) begin : g_path
			assign eof_hit[i] = RX_EOF_I[i]
				&& (s_q.rx_path == PATH_CODE[i]);
			assign bad_hit[i] = eof_hit[i] && RX_CRC_BAD_I[i];
			assign tx_nx[i]   = (s_q.txsel == PATH_CODE[i])
				? gen_beat : NORM_TX_I[i];
		end
	endgenerate

	tg_pktgen u_gen (
		.clk_i   (SYS_CLK_I),
		.nrst_i  (NRST_I),
		.run_i   (s_q.pg_path != 3'h0),
		.long_i  (s_q.pg_long),
		.fixed_i (s_q.pg_fixed),
		.bad_i   (s_q.pg_bad),
		.beat_o  (gen_beat),
		.busy_o  (gen_busy),
		.done_o  (pkt_done)
	);

	tg_prbs #(.IS_CHECK(1'b0), .LOCK_BITS(LOCK_BITS)) u_prbs_gen (
		.clk_i  (SYS_CLK_I),
		.nrst_i (NRST_I),
		.en_i   (s_q.gen_en),
		.pat_i  (s_q.pat),
		.bit_i  (1'b0),
		.bit_o  (gen_bit),
		.err_o  (),
		.lock_o ()
	);

	tg_prbs #(.IS_CHECK(1'b1), .LOCK_BITS(LOCK_BITS)) u_prbs_chk (
		.clk_i  (SYS_CLK_I),
		.nrst_i (NRST_I),
		.en_i   (s_q.chk_en),
		.pat_i  (s_q.pat),
		.bit_i  (SER_RX_I ^ ~s_q.chk_pol),
		.bit_o  (),
		.err_o  (chk_err),
		.lock_o (chk_lock)
	);

	always_comb begin
		s_d     = s_q;
		wr_fire = 1'b0;
		rd_fire = 1'b0;
		wd      = 16'h0000;
		wr_look = rd_val(s_q.awaddr, s_q);
		rd_look = rd_val(ARADDR_I, s_q);

		// rx counters, saturating so a long run never reads low
		if (|eof_hit && s_q.fcnt != 8'hFF) begin
			s_d.fcnt = s_q.fcnt + 8'h01;
		end
		if (|bad_hit && s_q.ecnt != 8'hFF) begin
			s_d.ecnt = s_q.ecnt + 8'h01;
		end

		// burst bookkeeping; zero burst size never ends the run
		if (s_q.pg_path == 3'h0) begin
			s_d.sent = 8'h00;
		end else if (pkt_done && s_q.pg_burst != 8'h00) begin
			if (s_q.sent + 8'h01 == s_q.pg_burst) begin
				s_d.pg_path = 3'h0;
				s_d.sent    = 8'h00;
			end else begin
				s_d.sent = s_q.sent + 8'h01;
			end
		end
		// the path is held while a packet is out so it is never cut
		s_d.txsel = gen_busy ? s_q.txsel : s_q.pg_path;
		s_d.tx    = tx_nx;

		// prbs side
		s_d.ser_tx = gen_bit ^ ~s_q.gen_pol;
		if (s_q.chk_en && chk_err && (!s_q.lockreq || chk_lock)
			&& s_q.perr != 32'hFFFFFFFF) begin
			s_d.perr = s_q.perr + 32'h00000001;
		end

		// write channel
		if (s_q.bvalid && BREADY_I) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
			wr_fire    = 1'b1;
			wd[15:8]   = s_q.wstrb[1] ? s_q.wdata[15:8] : wr_look[15:8];
			wd[7:0]    = s_q.wstrb[0] ? s_q.wdata[7:0] : wr_look[7:0];
			s_d.bvalid = 1'b1;
			s_d.bresp  = wr_look[16] ? `TG_RESP_OKAY : `TG_RESP_SLVERR;
			s_d.aw_full = 1'b0;
			s_d.w_full  = 1'b0;
			if (s_q.awaddr == `TG_OFF_RXCTL) begin
				s_d.rx_path = wd[2:0];
				if (wd[2:0] == 3'h0 || wd[`TG_RX_CLR_BIT]) begin
					s_d.fcnt = 8'h00;
					s_d.ecnt = 8'h00;
				end
			end else if (s_q.awaddr == `TG_OFF_PGCTL) begin
				s_d.pg_burst = wd[`TG_PG_BURST_LSB +: 8];
				s_d.pg_path  = wd[`TG_PG_PATH_LSB +: 3];
				s_d.pg_fixed = wd[`TG_PG_FIXED_BIT];
				s_d.pg_long  = wd[`TG_PG_LONG_BIT];
				s_d.pg_bad   = wd[`TG_PG_BAD_BIT];
			end else if (s_q.awaddr == `TG_OFF_PRBSCTL) begin
				s_d.chk_pol = wd[`TG_PR_CHKPOL];
				s_d.gen_pol = wd[`TG_PR_GENPOL];
				s_d.lockreq = wd[`TG_PR_LOCK];
				s_d.pat     = wd[`TG_PR_PAT_LSB +: 2];
				s_d.chk_en  = wd[`TG_PR_CHKEN];
				s_d.gen_en  = wd[`TG_PR_GENEN];
				if (wd[`TG_PR_CLR]) begin
					s_d.perr = 32'h00000000;
					s_d.phi  = 16'h0000;
				end
			end
		end
		if (AWVALID_I && s_q.awrdy) begin
			s_d.aw_full = 1'b1;
			s_d.awaddr  = AWADDR_I;
		end
		if (WVALID_I && s_q.wrdy) begin
			s_d.w_full = 1'b1;
			s_d.wdata  = WDATA_I;
			s_d.wstrb  = WSTRB_I;
		end
		s_d.awrdy = !s_d.aw_full;
		s_d.wrdy  = !s_d.w_full;

		// read channel; reads never disturb the rx counts
		if (s_q.rvalid && RREADY_I) begin
			s_d.rvalid = 1'b0;
		end
		if (ARVALID_I && s_q.arrdy) begin
			rd_fire    = 1'b1;
			s_d.rvalid = 1'b1;
			s_d.rdata  = {16'h0000, rd_look[15:0]};
			s_d.rresp  = rd_look[16] ? `TG_RESP_OKAY : `TG_RESP_SLVERR;
			if (ARADDR_I == `TG_OFF_ERRLO) begin
				s_d.phi = s_q.perr[31:16];
			end
		end
		s_d.arrdy = !s_d.rvalid;
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			s_q         <= '0;
			s_q.chk_pol <= `TG_POL_RST;
			s_q.gen_pol <= `TG_POL_RST;
			s_q.awrdy   <= 1'b1;
			s_q.wrdy    <= 1'b1;
			s_q.arrdy   <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign AWREADY_O = s_q.awrdy;
	assign WREADY_O  = s_q.wrdy;
	assign BVALID_O  = s_q.bvalid;
	assign BRESP_O   = s_q.bresp;
	assign ARREADY_O = s_q.arrdy;
	assign RVALID_O  = s_q.rvalid;
	assign RDATA_O   = s_q.rdata;
	assign RRESP_O   = s_q.rresp;
	assign TX_O      = s_q.tx;
	assign SER_TX_O  = s_q.ser_tx;

	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!NRST_I);

	sequence s_burst_end;
		pkt_done && s_q.pg_burst != 8'h00
		&& s_q.sent + 8'h01 == s_q.pg_burst && !wr_fire;
	endsequence

	sequence s_lo_read;
		rd_fire && ARADDR_I == `TG_OFF_ERRLO;
	endsequence

	cnt_idle_a: assert property (
		s_q.rx_path == 3'h0 |-> s_q.fcnt == 8'h00 && s_q.ecnt == 8'h00)
		else $error("counts not zero while rx path is off");
	cnt_sat_a: assert property (
		s_q.fcnt == 8'hFF && !wr_fire |=> s_q.fcnt == 8'hFF)
		else $error("frame count wrapped");
	cnt_read_a: assert property (
		rd_fire && ARADDR_I == `TG_OFF_CNTS
		|=> RDATA_O[15:0] == {$past(s_q.fcnt), $past(s_q.ecnt)}
		&& RVALID_O)
		else $error("count readback wrong");
	burst_stop_a: assert property (
		s_burst_end |=> s_q.pg_path == 3'h0 ##[1:13] !gen_busy)
		else $error("burst did not end");
	norm_pass_a: assert property (
		s_q.txsel == 3'h0 |=> TX_O == $past(NORM_TX_I))
		else $error("normal traffic blocked");
	hi_snap_a: assert property (
		s_lo_read |=> s_q.phi == $past(s_q.perr[31:16])
		&& RDATA_O[15:0] == $past(s_q.perr[15:0]))
		else $error("high half not snapped on low read");
	hi_hold_a: assert property (
		!(rd_fire && ARADDR_I == `TG_OFF_ERRLO) && !wr_fire
		|=> $stable(s_q.phi))
		else $error("high half moved without low read");
	err_clr_a: assert property (
		wr_fire && s_q.awaddr == `TG_OFF_PRBSCTL && wd[`TG_PR_CLR]
		|=> s_q.perr == 32'h00000000)
		else $error("prbs error count not cleared");
	lock_gate_a: assert property (
		s_q.lockreq && !chk_lock && !wr_fire |=> $stable(s_q.perr))
		else $error("errors counted before lock");

	// each tx path carries the generator only while it is selected
	tx_copper_a: assert property (
		s_q.txsel == `TG_PATH_COPPER |=> TX_O[0] == $past(gen_beat))
		else $error("copper path missed generator beat");
	tx_serial_a: assert property (
		s_q.txsel == `TG_PATH_SERIAL |=> TX_O[1] == $past(gen_beat))
		else $error("serial mac path missed generator beat");
	tx_par_a: assert property (
		s_q.txsel == `TG_PATH_PAR |=> TX_O[2] == $past(gen_beat))
		else $error("parallel mac path missed generator beat");
	cnt_hold_a: assert property (
		!(|eof_hit) && !wr_fire |=> $stable(s_q.fcnt))
		else $error("frame count moved without a frame");
	ecnt_sat_a: assert property (
		s_q.ecnt == 8'hFF && !wr_fire |=> s_q.ecnt == 8'hFF)
		else $error("crc error count wrapped");
	cnt_clr_a: assert property (
		wr_fire && s_q.awaddr == `TG_OFF_RXCTL && wd[`TG_RX_CLR_BIT]
		|=> s_q.fcnt == 8'h00 && s_q.ecnt == 8'h00)
		else $error("clear bit left counts standing");
	// a stopped generator must hand the path back to normal traffic
	gen_idle_a: assert property (
		s_q.pg_path == 3'h0 && !gen_busy |=> s_q.txsel == 3'h0)
		else $error("tx path still held after generator stopped");

endmodule

//--- tg_consts.svh
// register offsets, field positions, reset values and byte counts
// assumes one generated byte per clock on the transmit side
`ifndef TG_CONSTS_SVH
`define TG_CONSTS_SVH

`define TG_OFF_RXCTL    8'h00
`define TG_OFF_CNTS     8'h04
`define TG_OFF_PGCTL    8'h08
`define TG_OFF_PRBSCTL  8'h0C
`define TG_OFF_ERRLO    8'h10
`define TG_OFF_ERRHI    8'h14

`define TG_RX_CLR_BIT   4
`define TG_PG_BURST_LSB 8
`define TG_PG_PATH_LSB  5
`define TG_PG_FIXED_BIT 2
`define TG_PG_LONG_BIT  1
`define TG_PG_BAD_BIT   0
`define TG_PR_CHKPOL    7
`define TG_PR_GENPOL    6
`define TG_PR_LOCK      5
`define TG_PR_CLR       4
`define TG_PR_PAT_LSB   2
`define TG_PR_CHKEN     1
`define TG_PR_GENEN     0

`define TG_PATH_COPPER  3'h2
`define TG_PATH_SERIAL  3'h4
`define TG_PATH_PAR     3'h6

`define TG_POL_RST      1'h1
`define TG_RESP_OKAY    2'h0
`define TG_RESP_SLVERR  2'h2

`define TG_PRE_BYTES    11'h008
`define TG_IPG_BYTES    11'h00C
`define TG_FCS_BYTES    11'h004
`define TG_LEN_SHORT    11'h040
`define TG_LEN_LONG     11'h5EE
`define TG_PRE_BYTE     8'h55
`define TG_SFD_BYTE     8'hD5
`define TG_PAT_EVEN     8'h5A
`define TG_PAT_ODD      8'hA5
`define TG_CRC_POLY     32'hEDB88320
`define TG_CRC_INIT     32'hFFFFFFFF
`define TG_LFSR_SEED    8'hFF
`define TG_PRBS_SEED    31'h7FFFFFFF
`define TG_LOCK_BITS    6'h20

`endif

//--- tg_pkg.sv
// types shared by the traffic test generator and checker
// assumes the constants header is compiled alongside
package tg_pkg;

	typedef struct packed {
		logic [7:0] data;
		logic       en;
		logic       er;
	} tg_beat_t;

	typedef enum logic [4:0] {
		GS_IDLE = 5'h01,
		GS_PRE  = 5'h02,
		GS_DATA = 5'h04,
		GS_CRC  = 5'h08,
		GS_GAP  = 5'h10
	} tg_gen_st_t;

	typedef struct packed {
		tg_gen_st_t  st;
		logic [10:0] cnt;
		logic [31:0] crc;
		logic [7:0]  lfsr;
		tg_beat_t    beat;
		logic        done;
	} tg_gen_state_t;

	typedef struct packed {
		logic [30:0] sr;
		logic        bit_v;
		logic        err;
		logic [5:0]  good;
		logic        lock;
	} tg_prbs_state_t;

	typedef struct packed {
		logic           aw_full;
		logic [7:0]     awaddr;
		logic           w_full;
		logic [31:0]    wdata;
		logic [3:0]     wstrb;
		logic           awrdy;
		logic           wrdy;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           arrdy;
		logic           rvalid;
		logic [31:0]    rdata;
		logic [1:0]     rresp;
		logic [2:0]     rx_path;
		logic [7:0]     fcnt;
		logic [7:0]     ecnt;
		logic [7:0]     pg_burst;
		logic [2:0]     pg_path;
		logic           pg_fixed;
		logic           pg_long;
		logic           pg_bad;
		logic [7:0]     sent;
		logic [2:0]     txsel;
		tg_beat_t [2:0] tx;
		logic           chk_pol;
		logic           gen_pol;
		logic           lockreq;
		logic [1:0]     pat;
		logic           chk_en;
		logic           gen_en;
		logic [31:0]    perr;
		logic [15:0]    phi;
		logic           ser_tx;
	} tg_main_state_t;

endpackage

//--- tg_prbs.sv
// serial prbs sequence unit, one bit per clock, generator or checker
// assumes the serial link presents one bit per system clock
`timescale 1ns/1ps
`include "tg_consts.svh"
module tg_prbs
	import tg_pkg::*;
#(
	parameter bit         IS_CHECK  = 1'b0,
	parameter logic [5:0] LOCK_BITS = `TG_LOCK_BITS
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       en_i,
	input  wire logic [1:0] pat_i,
	input  wire logic       bit_i,
	output      logic       bit_o,
	output      logic       err_o,
	output      logic       lock_o
);

	tg_prbs_state_t s_q;
	tg_prbs_state_t s_d;
	logic           tap;

	always_comb begin
		s_d = s_q;
		case (pat_i)
			2'h0:    tap = s_q.sr[6] ^ s_q.sr[5];
			2'h1:    tap = s_q.sr[22] ^ s_q.sr[17];
			2'h2:    tap = s_q.sr[30] ^ s_q.sr[27];
			default: tap = ~s_q.sr[0];
		endcase
		s_d.err = 1'b0;
		if (!en_i) begin
			s_d.sr   = `TG_PRBS_SEED;
			s_d.good = 6'h00;
			s_d.lock = 1'b0;
		end else if (IS_CHECK) begin
			// self-synchronising: received bits feed the predictor
			s_d.err = tap ^ bit_i;
			s_d.sr  = {s_q.sr[29:0], bit_i};
			if (s_d.err) begin
				s_d.good = 6'h00;
			end else if (s_q.good != LOCK_BITS) begin
				s_d.good = s_q.good + 6'h01;
			end
			s_d.lock = s_q.lock | (s_q.good == LOCK_BITS);
		end else begin
			s_d.sr    = {s_q.sr[29:0], tap};
			s_d.bit_v = tap;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q      <= '0;
			s_q.sr   <= `TG_PRBS_SEED;
		end else begin
			s_q <= s_d;
		end
	end

	assign bit_o  = s_q.bit_v;
	assign err_o  = s_q.err;
	assign lock_o = s_q.lock;

endmodule

//--- tg_pktgen.sv
// short or long packet generator: preamble, payload, crc and gap
// assumes one byte leaves per clock; run_i is sampled between packets
`timescale 1ns/1ps
`include "tg_consts.svh"
module tg_pktgen
	import tg_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic run_i,
	input  wire logic long_i,
	input  wire logic fixed_i,
	input  wire logic bad_i,
	output      tg_beat_t beat_o,
	output      logic     busy_o,
	output      logic     done_o
);

	tg_gen_state_t g_q;
	tg_gen_state_t g_d;
	logic [10:0]   lastd;
	logic [7:0]    pb;
	logic [31:0]   fcs;

	function automatic logic [31:0] crc_upd(input logic [31:0] c,
		input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ `TG_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	always_comb begin
		g_d      = g_q;
		g_d.done = 1'b0;
		g_d.beat = '0;
		// payload runs to the length minus the four fcs bytes
		lastd = (long_i ? `TG_LEN_LONG : `TG_LEN_SHORT)
			- `TG_FCS_BYTES - 11'h001;
		pb  = fixed_i ? (g_q.cnt[0] ? `TG_PAT_ODD : `TG_PAT_EVEN)
			: g_q.lfsr;
		fcs = bad_i ? g_q.crc : ~g_q.crc;
		case (g_q.st)
			GS_IDLE: begin
				if (run_i) begin
					g_d.st  = GS_PRE;
					g_d.cnt = 11'h000;
				end
			end
			GS_PRE: begin
				g_d.beat.en   = 1'b1;
				g_d.beat.data = `TG_PRE_BYTE;
				g_d.cnt       = g_q.cnt + 11'h001;
				if (g_q.cnt == `TG_PRE_BYTES - 11'h001) begin
					g_d.beat.data = `TG_SFD_BYTE;
					g_d.st        = GS_DATA;
					g_d.cnt       = 11'h000;
					g_d.crc       = `TG_CRC_INIT;
				end
			end
			GS_DATA: begin
				g_d.lfsr = {g_q.lfsr[6:0],
					g_q.lfsr[7] ^ g_q.lfsr[5] ^ g_q.lfsr[4] ^ g_q.lfsr[3]};
				g_d.crc       = crc_upd(g_q.crc, pb);
				g_d.beat.en   = 1'b1;
				g_d.beat.data = pb;
				g_d.beat.er   = bad_i && (g_q.cnt == 11'h000);
				g_d.cnt       = g_q.cnt + 11'h001;
				if (g_q.cnt == lastd) begin
					g_d.st  = GS_CRC;
					g_d.cnt = 11'h000;
				end
			end
			GS_CRC: begin
				g_d.beat.en   = 1'b1;
				g_d.beat.data = fcs[{g_q.cnt[1:0], 3'h0} +: 8];
				g_d.cnt       = g_q.cnt + 11'h001;
				if (g_q.cnt == `TG_FCS_BYTES - 11'h001) begin
					g_d.st   = GS_GAP;
					g_d.cnt  = 11'h000;
					g_d.done = 1'b1;
				end
			end
			GS_GAP: begin
				if (!run_i) begin
					g_d.st = GS_IDLE;
				end else if (g_q.cnt == `TG_IPG_BYTES - 11'h001) begin
					g_d.st  = GS_PRE;
					g_d.cnt = 11'h000;
				end else begin
					g_d.cnt = g_q.cnt + 11'h001;
				end
			end
			default: g_d.st = GS_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			g_q      <= '0;
			g_q.st   <= GS_IDLE;
			g_q.lfsr <= `TG_LFSR_SEED;
		end else begin
			g_q <= g_d;
		end
	end

	assign beat_o = g_q.beat;
	assign busy_o = (g_q.st != GS_IDLE);
	assign done_o = g_q.done;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_pre;
		(g_q.st == GS_PRE) [*8] ##1 (g_q.st == GS_DATA);
	endsequence

	pre_len_a: assert property (
		((g_q.st == GS_IDLE) || (g_q.st == GS_GAP && g_q.cnt == 11'h00B))
		&& run_i |=> s_pre)
		else $error("preamble is not eight bytes");
	pkt_len_a: assert property (
		$rose(g_q.st == GS_CRC) |-> $past(g_q.cnt) == $past(lastd))
		else $error("payload length wrong");
	gap_len_a: assert property (
		$rose(g_q.st == GS_GAP) |-> g_q.cnt == 11'h000 ##1 !g_q.beat.en)
		else $error("gap does not start clean");
	sym_err_a: assert property (
		g_q.beat.er |-> $past(bad_i) && $past(g_q.st) == GS_DATA)
		else $error("symbol error without error packet");

endmodule

//--- tg_peer.sv
// far-side model: mac rx frame flags, normal tx traffic, serial peer
// assumes the bench calls frame() and sets inj from its own sequence
`timescale 1ns/1ps
module tg_peer
	import tg_pkg::*;
(
	input  wire logic           clk_i,
	input  wire logic           ser_tx_i,
	output      logic           ser_rx_o,
	output      logic [2:0]     eof_o,
	output      logic [2:0]     bad_o,
	output      tg_beat_t [2:0] norm_o
);
	logic       inj = 1'b0;
	logic [7:0] cnt_q = 8'h00;

	// link loops back; inj flips bits so the checker sees errors
	assign ser_rx_o = ser_tx_i ^ inj;

	// data moves every cycle so a stale copy never matches;
	// en stays low so generated frames stand out on every path
	always @(posedge clk_i) begin
		cnt_q <= cnt_q + 8'h01;
	end

	always_comb begin
		for (int k = 0; k < 3; k++) begin
			norm_o[k] = '{data: cnt_q + 8'(k * 85), en: 1'b0, er: cnt_q[0]};
		end
	end

	initial begin
		eof_o = 3'h0;
		bad_o = 3'h0;
	end

	// one-cycle end-of-frame pulse with its crc verdict
	task frame(input int k, input logic b);
		@(posedge clk_i);
		eof_o[k] <= 1'b1;
		bad_o[k] <= b;
		@(posedge clk_i);
		eof_o <= 3'h0;
		bad_o <= 3'h0;
	endtask
endmodule

//--- tb_traffic_test_gen_check.sv
// self-checking bench for tg_top: reset values, rx counters, generator
// and prbs; tg_peer plays the mac side and the serial link partner
`timescale 1ns/1ps
`include "tg_consts.svh"
module tb_traffic_test_gen_check
	import tg_pkg::*;
;
	logic           clk = 1'b0;
	logic           rst_n = 1'b0;
	logic [7:0]     awaddr = 8'h00;
	logic [7:0]     araddr = 8'h00;
	logic [31:0]    wdata = 32'h0;
	logic           awvalid = 1'b0;
	logic           wvalid = 1'b0;
	logic           bready = 1'b0;
	logic           arvalid = 1'b0;
	logic           rready = 1'b0;
	logic           awready, wready, bvalid, arready, rvalid;
	logic           ser_tx, ser_rx, er;
	logic [1:0]     bresp, rresp, resp;
	logic [31:0]    rdata, v, lo;
	logic [2:0]     eof, bad;
	tg_beat_t [2:0] norm, tx;
	logic [7:0]     q [$];
	logic [99:0]    s;
	int             errors = 0;
	int             n_tests = 0;
	int             nfr, gap;
	logic [7:0]     ra [7] = '{`TG_OFF_RXCTL, `TG_OFF_CNTS, `TG_OFF_PGCTL,
		`TG_OFF_PRBSCTL, `TG_OFF_ERRLO, `TG_OFF_ERRHI, 8'h18};
	logic [31:0]    rv [7] = '{0, 0, 0, 32'hC0, 0, 0, 0};
	logic [1:0]     rr [7] = '{0, 0, 0, 0, 0, 0, 2'h2};

	tg_top tg_top_i (
		.SYS_CLK_I(clk), .NRST_I(rst_n),
		.AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
		.WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid),
		.WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
		.BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
		.ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
		.RVALID_O(rvalid), .RREADY_I(rready), .RX_EOF_I(eof),
		.RX_CRC_BAD_I(bad), .NORM_TX_I(norm), .TX_O(tx),
		.SER_TX_O(ser_tx), .SER_RX_I(ser_rx)
	);

	tg_peer tg_peer_i (
		.clk_i(clk), .ser_tx_i(ser_tx), .ser_rx_o(ser_rx),
		.eof_o(eof), .bad_o(bad), .norm_o(norm)
	);

	always #5 clk = ~clk;

	task chk(input string nm, input logic [31:0] sn, ex);
		n_tests++;
		if (sn !== ex) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, ex, sn);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		resp = bresp;
		bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] ex);
		rd(a);
		chk($sformatf("reg %h", a), v, ex);
	endtask

	task f(input int k, input logic b);
		tg_peer_i.frame(k, b);
	endtask

	task inj(input int n);
		@(posedge clk);
		tg_peer_i.inj <= 1'b1;
		repeat (n) @(posedge clk);
		tg_peer_i.inj <= 1'b0;
	endtask

	// records the first frame on path p and the gap that follows it
	task mon(input int p, input int n);
		logic pv;
		nfr = 0;
		gap = 0;
		er = 1'b0;
		pv = 1'b0;
		q.delete();
		repeat (n) begin
			@(posedge clk);
			if (tx[p].en && !pv) nfr++;
			if (tx[p].en && nfr == 1) q.push_back(tx[p].data);
			if (tx[p].en && nfr == 1) er = er | tx[p].er;
			if (!tx[p].en && nfr == 1) gap++;
			pv = tx[p].en;
		end
	endtask

	// crc over frame and fcs leaves a fixed residue when the fcs is good
	function automatic logic [31:0] crc_res();
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		for (int i = 8; i < q.size(); i++) begin
			c = c ^ {24'h0, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
		end
		return c;
	endfunction

	task pchk(input int p);
		tg_beat_t b;
		@(posedge clk);
		b = norm[p];
		@(posedge clk);
		chk("normal tx", {22'h0, tx[p]}, {22'h0, b});
	endtask

	// each of the 40 newest serial bits must follow the recurrence of the chosen pattern
	task pseq(input int p);
		int ta, tb, n;
		ta = p == 0 ? 7 : p == 1 ? 23 : 31;
		tb = p == 0 ? 6 : p == 1 ? 18 : 28;
		n = 0;
		repeat (100) begin
			@(posedge clk);
			s = {s[98:0], ser_tx};
		end
		for (int j = 0; j < 40; j++)
			n += (p == 3 ? ~s[j+1] : s[j+ta] ^ s[j+tb]) !== s[j];
		chk("prbs sequence", n, 0);
	endtask

	task stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// whole run is some 5.5k cycles; cut off at 30k
	initial begin
		#300000;
		errors++;
		stop_test();
	end

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(ra[i]);
			chk("reset value", v, rv[i]);
			chk("read resp", {30'h0, resp}, {30'h0, rr[i]});
		end
		for (int k = 0; k < 3; k++) pchk(k);
		$display("test reset finished");

		f(0, 1'b1);
		rchk(`TG_OFF_CNTS, 32'h0);
		wr(`TG_OFF_RXCTL, 32'h2);
		f(0, 1'b1);
		f(0, 1'b1);
		f(0, 1'b0);
		f(1, 1'b1);
		rchk(`TG_OFF_CNTS, 32'h0302);
		wr(`TG_OFF_CNTS, 32'hFFFF);
		rchk(`TG_OFF_CNTS, 32'h0302);
		for (int k = 1; k < 3; k++) begin
			wr(`TG_OFF_RXCTL, 32'h0);
			rchk(`TG_OFF_CNTS, 32'h0);
			wr(`TG_OFF_RXCTL, 2 * k + 2);
			f(k, 1'b1);
			f(k - 1, 1'b1);
			rchk(`TG_OFF_CNTS, 32'h0101);
		end
		repeat (260) f(2, 1'b1);
		rchk(`TG_OFF_CNTS, 32'hFFFF);
		wr(`TG_OFF_RXCTL, 32'h16);
		rchk(`TG_OFF_CNTS, 32'h0);
		rchk(`TG_OFF_RXCTL, 32'h6);
		f(2, 1'b0);
		rchk(`TG_OFF_CNTS, 32'h0100);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rchk(`TG_OFF_CNTS, 32'h0);
		$display("test rx counters finished");

		for (int k = 0; k < 3; k++) begin
			wr(`TG_OFF_PGCTL, 32'h0204 | ((2 * k + 2) << 5));
			mon(k, 230);
			chk("frames", nfr, 2);
			chk("length", q.size(), 72);
			chk("gap", gap, 12);
			chk("preamble", {q[0], q[6], q[7]}, 24'h5555D5);
			chk("payload", {q[8], q[9], q[67]}, 24'h5AA5A5);
			chk("crc", crc_res(), 32'hDEBB20E3);
			chk("symbol error", er, 1'b0);
			rchk(`TG_OFF_PGCTL, 32'h0204);
		end
		wr(`TG_OFF_PGCTL, 32'h43);
		fork
			mon(0, 3300);
			begin
				repeat (1600) @(posedge clk);
				wr(`TG_OFF_PGCTL, 32'h0);
			end
		join
		chk("frames", nfr, 2);
		chk("length", q.size(), 1526);
		chk("symbol error", er, 1'b1);
		chk("crc good", crc_res() == 32'hDEBB20E3, 1'b0);
		pchk(0);
		$display("test packet generator finished");

		wr(`TG_OFF_PRBSCTL, 32'h73);
		repeat (60) @(posedge clk);
		rchk(`TG_OFF_ERRLO, 32'h0);
		wr(`TG_OFF_PRBSCTL, 32'h53);
		repeat (50) @(posedge clk);
		rd(`TG_OFF_ERRLO);
		chk("free run errors", v == 32'h0, 1'b0);
		rchk(`TG_OFF_ERRHI, 32'h0);
		for (int p = 0; p < 4; p++) begin
			wr(`TG_OFF_PRBSCTL, 32'hE3 | (p << 2));
			pseq(p);
			wr(`TG_OFF_PRBSCTL, 32'hF3 | (p << 2));
			rchk(`TG_OFF_ERRLO, 32'h0);
			rchk(`TG_OFF_PRBSCTL, 32'hE3 | (p << 2));
		end
		wr(`TG_OFF_PRBSCTL, 32'h03);
		repeat (50) @(posedge clk);
		wr(`TG_OFF_PRBSCTL, 32'h13);
		repeat (50) @(posedge clk);
		rchk(`TG_OFF_ERRLO, 32'h0);
		wr(`TG_OFF_PRBSCTL, 32'hD3);
		repeat (50) @(posedge clk);
		inj(1);
		inj(1);
		inj(1);
		// a flipped bit is counted again as it passes both taps
		repeat (20) @(posedge clk);
		rd(`TG_OFF_ERRLO);
		lo = v;
		chk("injected errors", lo == 32'h0, 1'b0);
		rchk(`TG_OFF_ERRLO, lo);
		rchk(`TG_OFF_ERRHI, 32'h0);
		wr(`TG_OFF_PRBSCTL, 32'hD3);
		rchk(`TG_OFF_ERRLO, 32'h0);
		rchk(`TG_OFF_PRBSCTL, 32'hC3);
		wr(`TG_OFF_PRBSCTL, 32'hD1);
		inj(20);
		rchk(`TG_OFF_ERRLO, 32'h0);
		$display("test prbs finished");
		stop_test();
	end
endmodule
